// ### core/asrw_pkg.sv
// asrw_pkg: constants for the asynchronous static memory host controller
// assumes a 200 MHz system clock; all timing counts are cycles of it
package asrw_pkg;
  localparam int ADDR_W        = 19;
  localparam int DATA_W        = 8;
  localparam int CLK_PERIOD_PS = 5000;
  // memory timing figures in ns
  localparam int T_READ_CYCLE_NS  = 45;
  localparam int T_ADDR_ACCESS_NS = 45;
  localparam int T_OE_ACCESS_NS   = 20;
  localparam int T_WRITE_CYCLE_NS = 45;
  localparam int T_WE_PULSE_NS    = 35;
  localparam int T_CE_WRITE_NS    = 35;
  localparam int T_ADDR_SETUP_NS  = 35;
  localparam int T_DATA_SETUP_NS  = 25;
  localparam int T_BUS_RELEASE_NS = 5;
  localparam int T_WE_HIZ_NS      = 15;
  // least times round up to whole cycles
  localparam int RD_CYC  = (T_READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WE_CYC  = (T_WE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WC_CYC  = (T_WRITE_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HIZ_CYC = (T_WE_HIZ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REL_CYC = (T_BUS_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W   = 8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_WR_SETUP, ST_WR_PULSE, ST_WR_RECOVER
  } asrw_state_type;
endpackage

// ### core/asrw_counter.sv
// asrw_counter: down counter for strobe phase lengths
// loaded by the controller at each phase start; done when it reaches one
`timescale 1ns/1ps
module asrw_counter #(
  parameter int W = 8
) (
  input  wire logic         clk_sys, // system clock
  input  wire logic         resetn,  // async reset, active low
  input  wire logic         load,    // load a new phase length
  input  wire logic [W-1:0] value,   // phase length in cycles, at least one
  output logic              done     // current phase ends this cycle
);
  logic [W-1:0] count;
  assign done = (count <= W'(1));
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end
endmodule

// ### core/asrw_ctrl.sv
// asrw_ctrl: host controller for a byte-wide asynchronous static memory
// drives chip select, output enable, write strobe, address and data pins;
// the memory is clockless and the data pins are split into in/out/enable.
// assumes the user holds a request until it is taken; nothing is dropped.
// Functional notes
// - write strobe stays high throughout every read
// - reads spaced 45 ns; data sampled 45 ns after address
// - back-to-back reads keep select and output enable low, only address changes
// - address valid no later than chip select falling
// - all signals valid before the last enabling strobe falls; reads drive address on the same edge that select and output enable fall
// - write data stable 25 ns before terminating edge
// - write data held until at least the terminating edge
// - address stable 35 ns before write end
// - address unchanged until after write end
// - write strobe low at least 35 ns
// - write cycles 45 ns apart, select low 35 ns before end
// - select high before data retention supply reduction
`timescale 1ns/1ps
module asrw_ctrl #(
  parameter int ADDR_W = asrw_pkg::ADDR_W,
  parameter int DATA_W = asrw_pkg::DATA_W
) (
  input  wire logic              clk_sys,            // system clock, 200 MHz
  input  wire logic              resetn,             // async reset, active low
  input  wire logic              req_valid,          // user request present
  input  wire logic              req_write,          // 1 write, 0 read
  input  wire logic [ADDR_W-1:0] req_addr,           // byte address
  input  wire logic [DATA_W-1:0] req_wdata,          // write byte
  input  wire logic              retention_req,      // ask for select held high
  output logic                   req_ready,          // request taken when valid and ready
  output logic                   rsp_valid,          // one-cycle read data pulse
  output logic [DATA_W-1:0]      rsp_rdata,          // read byte
  output logic                   retention_safe,     // select is high, supply may drop
  output logic                   mem_cs_n,           // chip select, active low
  output logic                   mem_oe_n,           // output enable, active low
  output logic                   mem_we_n,           // write strobe, active low
  output logic [ADDR_W-1:0]      word_address_lines, // address pins
  input  wire logic [DATA_W-1:0] byte_data_lines_in, // data pins as seen
  output logic [DATA_W-1:0]      byte_data_lines_out,// data driven on pins
  output logic                   byte_data_lines_oe  // high while host drives data
);
  asrw_pkg::asrw_state_type state;
  asrw_pkg::asrw_state_type next_state;

  logic                   phase_done;
  logic                   load;
  logic [asrw_pkg::CNT_W-1:0] load_value;
  logic                   rd_last;

  wire take      = req_ready && req_valid;
  wire take_rd   = take && !req_write;
  wire take_wr   = take && req_write;
  wire in_read   = (state == asrw_pkg::ST_READ);
  // the read counter runs one short so the closing cycle is known a cycle
  // ahead; rd_last then marks that closing cycle
  wire rd_near   = in_read && phase_done && !rd_last;
  wire rd_end    = in_read && rd_last;
  // a read may chain straight into the next read without lifting select
  wire chain_ok  = rd_near && !load;

  // write setup: one cycle with address and data valid, select low, oe and we high, before we falls
  localparam int SETUP_CYC = 1;
  // pulse holds we low long enough for pulse width, data setup and address setup
  localparam int PULSE_CYC = (asrw_pkg::WE_CYC > asrw_pkg::HIZ_CYC) ? asrw_pkg::WE_CYC : asrw_pkg::HIZ_CYC;
  localparam int RECOV_A   = asrw_pkg::WC_CYC - SETUP_CYC - PULSE_CYC;
  localparam int RECOV_CYC = (RECOV_A > asrw_pkg::REL_CYC) ? RECOV_A : asrw_pkg::REL_CYC;
  // read length less the closing cycle that rd_last stands for; a read
  // therefore always spans at least two clocks
  localparam int RD_LOAD   = (asrw_pkg::RD_CYC > 1) ? asrw_pkg::RD_CYC - 1 : 1;

  always_comb begin
    next_state = state;
    load       = 1'b0;
    load_value = '0;
    case (state)
      asrw_pkg::ST_IDLE, asrw_pkg::ST_READ: begin
        if (take_rd) begin
          next_state = asrw_pkg::ST_READ;
          load       = 1'b1;
          load_value = asrw_pkg::CNT_W'(RD_LOAD);
        end else if (take_wr) begin
          next_state = asrw_pkg::ST_WR_SETUP;
          load       = 1'b1;
          load_value = asrw_pkg::CNT_W'(SETUP_CYC);
        end else if (rd_end) begin
          next_state = asrw_pkg::ST_IDLE;
        end
      end
      asrw_pkg::ST_WR_SETUP: begin
        if (phase_done) begin
          next_state = asrw_pkg::ST_WR_PULSE;
          load       = 1'b1;
          load_value = asrw_pkg::CNT_W'(PULSE_CYC);
        end
      end
      asrw_pkg::ST_WR_PULSE: begin
        if (phase_done) begin
          next_state = asrw_pkg::ST_WR_RECOVER;
          load       = 1'b1;
          load_value = asrw_pkg::CNT_W'(RECOV_CYC);
        end
      end
      asrw_pkg::ST_WR_RECOVER: begin
        if (phase_done) begin
          next_state = asrw_pkg::ST_IDLE;
        end
      end
      default: next_state = asrw_pkg::ST_IDLE;
    endcase
  end

  asrw_counter #(
    .W(asrw_pkg::CNT_W)
  ) u_phase (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .load    (load),
    .value   (load_value),
    .done    (phase_done)
  );

  wire next_read     = (next_state == asrw_pkg::ST_READ);
  // select spans setup and pulse so it rises with we: we terminates the write
  wire next_cs_n     = !(next_read || (next_state == asrw_pkg::ST_WR_SETUP)
                       || (next_state == asrw_pkg::ST_WR_PULSE));
  wire next_oe_n     = !next_read;
  wire next_we_n     = !(next_state == asrw_pkg::ST_WR_PULSE);
  // host drives data through setup and pulse, releases it with the rising strobe
  wire next_drive    = (next_state == asrw_pkg::ST_WR_SETUP) || (next_state == asrw_pkg::ST_WR_PULSE);
  // limitation: a write taken in the closing cycle of a read drives data
  // while the memory may still be turning its outputs off
  // ready rises a cycle early so a waiting read is taken in the closing
  // cycle of the current one and select never lifts between them
  wire next_ready    = !retention_req && ((next_state == asrw_pkg::ST_IDLE) || chain_ok);
  wire next_safe     = retention_req && next_cs_n && (next_state == asrw_pkg::ST_IDLE);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= asrw_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mem_cs_n           <= 1'b1;
      mem_oe_n           <= 1'b1;
      mem_we_n           <= 1'b1;
    end else begin
      mem_cs_n           <= next_cs_n;
      mem_oe_n           <= next_oe_n;
      mem_we_n           <= next_we_n;
    end
  end

  // data enable leaves on the same edge as the write strobe rises
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      byte_data_lines_oe <= 1'b0;
    end else begin
      byte_data_lines_oe <= next_drive;
    end
  end

  // address and data change only when a request is taken, so both stay put
  // through the terminating edge and the following recovery
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      word_address_lines  <= '0;
      byte_data_lines_out <= '0;
    end else if (take) begin
      word_address_lines  <= req_addr;
      byte_data_lines_out <= req_wdata;
    end
  end

  // read data is sampled on the last cycle of the read cycle, past access time
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= rd_end;
    end
  end

  // rsp_rdata keeps the last byte read until the next read closes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rsp_rdata <= '0;
    end else if (rd_end) begin
      rsp_rdata <= byte_data_lines_in;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_last <= 1'b0;
    end else begin
      rd_last <= rd_near && !load;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= next_ready;
    end
  end

  // safe rises on the edge that parks select high, or once it is parked, with the controller idle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      retention_safe <= 1'b0;
    end else begin
      retention_safe <= next_safe;
    end
  end
endmodule

// ### tb/asrw_mem_model.sv
// asrw_mem_model: behavioural byte-wide static memory with no clock
// assumes the bench feeds the host pin outputs; it resolves the data pins
`timescale 1ns/1ps
module asrw_mem_model (
  input  wire logic        cs_n,  // chip select
  input  wire logic        oe_n,  // output enable
  input  wire logic        we_n,  // write strobe
  input  wire logic [18:0] addr,  // address pins
  input  wire logic [7:0]  hd,    // host data
  input  wire logic        hd_oe, // host drives data
  output logic [7:0]       bus    // resolved data pins
);
  logic [7:0]  mem [0:524287];
  logic [7:0]  q = 8'h00;
  logic [7:0]  wd;
  logic [18:0] wa;
  logic        act = 1'b0;
  wire  [21:0] key = {cs_n, oe_n, we_n, addr};
  wire  [21:0] #44 key_d = key;
  // data shows only once the access time has run out; before that the pins toggle
  wire         drv = !cs_n && !oe_n && we_n && (key === key_d);
  always @* if (hd_oe) q = hd; else if (drv) q = mem[addr];
  assign bus = hd_oe ? hd : drv ? mem[addr] : ~q;
  always @(cs_n, we_n, addr, bus)
    if (!cs_n && !we_n) begin
      wa = addr;
      wd = bus;
      act = 1'b1;
    end else if (act) begin
      mem[wa] = wd;
      act = 1'b0;
    end
endmodule

// ### tb/asrw_ctrl_assertions.sv
// asrw_ctrl_assertions: pin timing checks for the memory host controller
// assumes one clock domain; bound to every asrw_ctrl instance
`timescale 1ns/1ps
module asrw_ctrl_assertions #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8
) (
  input wire logic              clk_sys,            // system clock
  input wire logic              resetn,             // async reset, active low
  input wire logic              rsp_valid,          // read data pulse
  input wire logic              retention_safe,     // select parked high
  input wire logic              mem_cs_n,           // chip select
  input wire logic              mem_oe_n,           // output enable
  input wire logic              mem_we_n,           // write strobe
  input wire logic [ADDR_W-1:0] word_address_lines, // address pins
  input wire logic [DATA_W-1:0] byte_data_lines_out,// host data
  input wire logic              byte_data_lines_oe  // host drives data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  rd_we_high_a: assert property (!mem_oe_n |-> mem_we_n) else $error("strobe low in read");
  rd_length_a: assert property ($fell(mem_oe_n) |=> (!mem_oe_n && !mem_cs_n)[*8]) else $error("read short");
  rd_answer_a: assert property (rsp_valid |-> !$past(mem_oe_n) && !$past(mem_cs_n, 9))
    else $error("answer early");
  wr_start_a: assert property ($fell(mem_we_n) |-> !mem_cs_n && byte_data_lines_oe &&
    $stable(word_address_lines) && $stable(byte_data_lines_out)) else $error("write setup");
  we_pulse_a: assert property ($fell(mem_we_n) |-> (!mem_we_n)[*7] ##1 mem_we_n) else $error("pulse width");
  wr_hold_a: assert property (!mem_we_n |=> $stable(word_address_lines) && $stable(byte_data_lines_out))
    else $error("write hold");
  cs_setup_a: assert property ($rose(mem_we_n) |-> !$past(mem_cs_n, 7)) else $error("select short");
  wr_space_a: assert property ($rose(mem_we_n) |-> mem_we_n[*2]) else $error("writes close");
  bus_free_a: assert property ($rose(mem_we_n) |-> !byte_data_lines_oe) else $error("bus held");
  ret_desel_a: assert property (retention_safe |-> mem_cs_n) else $error("select low");
  cover property (rsp_valid);
  cover property ($rose(mem_we_n));
  cover property ($rose(retention_safe));
endmodule
bind asrw_ctrl asrw_ctrl_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (.clk_sys(clk_sys),
  .resetn(resetn), .rsp_valid(rsp_valid), .retention_safe(retention_safe), .mem_cs_n(mem_cs_n),
  .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .word_address_lines(word_address_lines),
  .byte_data_lines_out(byte_data_lines_out), .byte_data_lines_oe(byte_data_lines_oe));

// ### tb/asrw_ctrl_bench.sv
// asrw_ctrl_bench: self-checking bench for the memory host controller
// assumes the behavioural memory model on the pins; inputs move 1 ns after the edge
`timescale 1ns/1ps
module asrw_ctrl_bench;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        req_valid = 1'b0, req_write = 1'b0, retention_req = 1'b0;
  logic [18:0] req_addr = 19'h0_0000, word_address_lines;
  logic [7:0]  req_wdata = 8'h00, rsp_rdata, byte_data_lines_in, byte_data_lines_out, v;
  logic        req_ready, rsp_valid, retention_safe, mem_cs_n, mem_oe_n, mem_we_n, byte_data_lines_oe;
  int          miscompares = 0, total_checks = 0;
  asrw_ctrl dut (.clk_sys, .resetn, .req_valid, .req_write, .req_addr, .req_wdata, .retention_req,
    .req_ready, .rsp_valid, .rsp_rdata, .retention_safe, .mem_cs_n, .mem_oe_n, .mem_we_n,
    .word_address_lines, .byte_data_lines_in, .byte_data_lines_out, .byte_data_lines_oe);
  asrw_mem_model u_mem (.cs_n(mem_cs_n), .oe_n(mem_oe_n), .we_n(mem_we_n), .addr(word_address_lines),
    .hd(byte_data_lines_out), .hd_oe(byte_data_lines_oe), .bus(byte_data_lines_in));
  initial forever #2.5 clk_sys = ~clk_sys;
  task chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // request stays up on return so back-to-back requests need no gap
  task access(input logic w, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid = 1'b1; req_write = w; req_addr = a; req_wdata = d;
    do begin @(posedge clk_sys); n++; end while (req_ready !== 1'b1 && n < 50);
    chk(req_ready === 1'b1, "request not taken");
    #1;
  endtask
  task get_rsp(output logic [7:0] r);
    int n;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (rsp_valid !== 1'b1 && n < 50);
    chk(rsp_valid === 1'b1, "no read answer");
    r = rsp_rdata;
    #1;
  endtask
  task t_write_read;
    logic [18:0] a [3];
    logic [7:0]  d [3];
    a = '{19'h0_0000, 19'h7_FFFF, 19'h2_AAAA};
    d = '{8'hA5, 8'h3C, 8'h5A};
    // the first read replaces the last write request with no idle gap
    for (int i = 0; i < 3; i++) access(1'b1, a[i], d[i]);
    for (int i = 0; i < 3; i++) begin
      access(1'b0, a[i], 8'h00);
      req_valid = 1'b0;
      get_rsp(v);
      chk(v === d[i], "read back");
    end
  endtask
  task t_chain;
    access(1'b0, 19'h7_FFFF, 8'h00);
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      chk(mem_cs_n === 1'b0 && mem_oe_n === 1'b0, "select dropped");
    end
    access(1'b0, 19'h2_AAAA, 8'h00);
    chk(mem_cs_n === 1'b0 && mem_we_n === 1'b1, "chain select");
    req_valid = 1'b0;
    get_rsp(v);
    chk(v === 8'h3C, "first chained");
    get_rsp(v);
    chk(v === 8'h5A, "second chained");
  endtask
  task t_retention;
    int n;
    n = 0;
    retention_req = 1'b1;
    do begin @(posedge clk_sys); n++; end while (retention_safe !== 1'b1 && n < 30);
    #1;
    chk(retention_safe === 1'b1 && mem_cs_n === 1'b1 && req_ready === 1'b0, "retention select");
    retention_req = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    t_write_read;
    t_chain;
    t_retention;
    print_verdict;
  end
endmodule
